// ==== hw/npec_ctrl.sv ====
// Program and erase sequencer with AHB-Lite register slave
`timescale 1ns/10ps
`include "npec_consts.svh"
module npec_ctrl
#(
   parameter int unsigned OP_CYCLES = `NPEC_OP_CYCLES
)
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [11:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // Mode pin and abort
   input wire logic i_serial_prog,
   input wire logic i_abort,
   // Memory array command
   output npec_pkg::npec_cmd_t o_cmd,
   output logic o_cmd_valid,
   output logic o_eeprom_program_only,
   output logic o_busy
);
   npec_pkg::npec_state_t state_r;
   npec_pkg::npec_ctrl_t ctrl_r;
   npec_pkg::npec_cmd_t cmd_r;
   logic [`NPEC_TBL_W-1:0] tblptr_r;
   logic serial_meta_r;
   logic serial_sync_r;
   logic abort_meta_r;
   logic abort_sync_r;
   logic wr_pend_r;
   logic [11:0] wr_addr_r;
   logic [2:0] dec_kind;
   logic [2:0] dec_rows;
   logic timer_done;
   logic wr_ctrl;
   logic set_start;
   logic launch;
   logic abort_run;
   logic [15:0] ctrl_rd;

   function automatic logic [15:0] ctrl_pack(npec_pkg::npec_ctrl_t c);
      logic [15:0] v;
      v = 16'h0;
      v[`NPEC_BIT_START] = c.start;
      v[`NPEC_BIT_OP_WRITE_ENABLE] = c.op_write_enable;
      v[`NPEC_BIT_ERR] = c.err;
      v[`NPEC_BIT_EEPROM_PROGRAM_ONLY] = c.eeprom_program_only;
      v[`NPEC_BIT_ERASE] = c.erase;
      v[5:0] = c.opcode;
      return v;
   endfunction

   // Pin synchronisers
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         serial_meta_r <= 1'b0;
         serial_sync_r <= 1'b0;
         abort_meta_r <= 1'b0;
         abort_sync_r <= 1'b0;
      end
      else
      begin
         serial_meta_r <= i_serial_prog;
         serial_sync_r <= serial_meta_r;
         abort_meta_r <= i_abort;
         abort_sync_r <= abort_meta_r;
      end
   end

   // Address phase capture
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h0;
      end
      else if (i_hready)
      begin
         wr_pend_r <= i_hsel && i_htrans[1] && i_hwrite;
         wr_addr_r <= i_haddr;
      end
   end

   // Read data from registers, answered in the data phase
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
         o_hrdata <= 32'h0;
      else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite)
      begin
         if (i_haddr == `NPEC_ADDR_CTRL)
            o_hrdata <= {16'h0, ctrl_rd};
         else if (i_haddr == `NPEC_ADDR_TBLPTR)
            o_hrdata <= {8'h0, tblptr_r};
         else if (i_haddr == `NPEC_ADDR_STATUS)
            o_hrdata <= {29'h0, cmd_r.kind};
         else
            o_hrdata <= 32'h0;
      end
   end

   assign ctrl_rd = ctrl_pack(ctrl_r);
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   assign wr_ctrl = wr_pend_r && (wr_addr_r == `NPEC_ADDR_CTRL);
   assign set_start = wr_ctrl && i_hwdata[`NPEC_BIT_START];
   // Launch needs enable, idle and a defined code
   assign launch = set_start && state_r == npec_pkg::NPEC_IDLE
      && ctrl_r.op_write_enable && dec_kind != `NPEC_OP_NONE;
   assign abort_run = abort_sync_r && state_r == npec_pkg::NPEC_BUSY;

   npec_decode u_decode
   (
      .i_erase(ctrl_r.erase),
      .i_opcode(ctrl_r.opcode),
      .i_serial_prog(serial_sync_r),
      .o_kind(dec_kind),
      .o_rows(dec_rows)
   );

   npec_timer #(.OP_CYCLES(OP_CYCLES)) u_timer
   (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_load(launch),
      .i_abort(abort_run),
      .o_done(timer_done)
   );

   // Table pointer
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
         tblptr_r <= 24'h0;
      else if (wr_pend_r && wr_addr_r == `NPEC_ADDR_TBLPTR
         && state_r != npec_pkg::NPEC_BUSY)
         tblptr_r <= i_hwdata[`NPEC_TBL_W-1:0];
   end

   // Sequencer state
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
         state_r <= npec_pkg::NPEC_IDLE;
      else
         case (state_r)
            npec_pkg::NPEC_IDLE:
               if (launch)
                  state_r <= npec_pkg::NPEC_BUSY;
            npec_pkg::NPEC_BUSY:
               if (abort_run || timer_done)
                  state_r <= npec_pkg::NPEC_DONE;
            npec_pkg::NPEC_DONE:
               state_r <= npec_pkg::NPEC_IDLE;
            default:
               state_r <= npec_pkg::NPEC_IDLE;
         endcase
   end

   // Control register fields
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
         ctrl_r <= '0;
      else
      begin
         if (wr_ctrl && state_r != npec_pkg::NPEC_BUSY)
         begin
            ctrl_r.op_write_enable <= i_hwdata[`NPEC_BIT_OP_WRITE_ENABLE];
            ctrl_r.eeprom_program_only <= i_hwdata[`NPEC_BIT_EEPROM_PROGRAM_ONLY];
            ctrl_r.erase <= i_hwdata[`NPEC_BIT_ERASE];
            ctrl_r.opcode <= i_hwdata[5:0];
         end
         if (launch)
            ctrl_r.start <= 1'b1;
         else if (state_r == npec_pkg::NPEC_BUSY
            && (timer_done || abort_run))
            ctrl_r.start <= 1'b0;
         // Error: set wins over software clear
         if (abort_run || (set_start && !launch))
            ctrl_r.err <= 1'b1;
         else if (launch)
            ctrl_r.err <= 1'b0;
         else if (wr_ctrl)
            ctrl_r.err <= i_hwdata[`NPEC_BIT_ERR];
      end
   end

   // Command to array, address from table pointer
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
         cmd_r <= '0;
      else if (launch)
      begin
         cmd_r.kind <= dec_kind;
         cmd_r.rows <= dec_rows;
         cmd_r.addr <= tblptr_r;
      end
   end

   assign o_cmd = cmd_r;
   assign o_cmd_valid = state_r == npec_pkg::NPEC_BUSY;
   // Program-only reaches EEPROM operations alone
   assign o_eeprom_program_only = ctrl_r.eeprom_program_only
      && cmd_r.kind == `NPEC_OP_EE;
   assign o_busy = ctrl_r.start;
endmodule // npec_ctrl

// ==== hw/npec_consts.svh ====
// Constants for the program and erase control block
`ifndef NPEC_CONSTS_SVH
`define NPEC_CONSTS_SVH
`define NPEC_ADDR_CTRL 12'h000
`define NPEC_ADDR_TBLPTR 12'h004
`define NPEC_ADDR_STATUS 12'h008
`define NPEC_BIT_START 15
`define NPEC_BIT_OP_WRITE_ENABLE 14
`define NPEC_BIT_ERR 13
`define NPEC_BIT_EEPROM_PROGRAM_ONLY 12
`define NPEC_BIT_ERASE 6
`define NPEC_CTRL_WMASK 16'h7060
`define NPEC_OP_DURATION_NS 32'd20000
`define NPEC_CLK_PERIOD_NS 32'd10
`define NPEC_OP_CYCLES (`NPEC_OP_DURATION_NS / `NPEC_CLK_PERIOD_NS)
`define NPEC_OP_NONE 3'h0
`define NPEC_OP_BOOT 3'h1
`define NPEC_OP_ALL 3'h2
`define NPEC_OP_ROW 3'h3
`define NPEC_OP_CFG 3'h4
`define NPEC_OP_EE 3'h5
`define NPEC_OP_PROG 3'h6
`define NPEC_TBL_W 24
`endif

// ==== hw/npec_pkg.sv ====
// Types for the program and erase control block
package npec_pkg;
   typedef enum logic [1:0]
   {
      NPEC_IDLE = 2'b00,
      NPEC_BUSY = 2'b01,
      NPEC_DONE = 2'b10
   } npec_state_t;

   typedef struct packed
   {
      logic [2:0] kind;
      logic [2:0] rows;
      logic [23:0] addr;
   } npec_cmd_t;

   typedef struct packed
   {
      logic start;
      logic op_write_enable;
      logic err;
      logic eeprom_program_only;
      logic erase;
      logic [5:0] opcode;
   } npec_ctrl_t;
endpackage

// ==== hw/npec_decode.sv ====
// Operation code decoder
`timescale 1ns/10ps
`include "npec_consts.svh"
module npec_decode
(
   // Selection
   input wire logic i_erase,
   input wire logic [5:0] i_opcode,
   input wire logic i_serial_prog,
   // Result
   output logic [2:0] o_kind,
   output logic [2:0] o_rows
);
   always_comb
   begin
      o_kind = `NPEC_OP_NONE;
      o_rows = 3'h0;
      if (i_erase)
      begin
         if (i_opcode[5:2] == 4'ha && i_serial_prog)
            o_kind = `NPEC_OP_BOOT;
         else if (i_opcode[5:2] == 4'h9 && i_serial_prog)
            o_kind = `NPEC_OP_ALL;
         else if (i_opcode == 6'h1a)
         begin
            o_kind = `NPEC_OP_ROW;
            o_rows = 3'h4;
         end
         else if (i_opcode == 6'h19)
         begin
            o_kind = `NPEC_OP_ROW;
            o_rows = 3'h2;
         end
         else if (i_opcode == 6'h18)
         begin
            o_kind = `NPEC_OP_ROW;
            o_rows = 3'h1;
         end
         else if (i_opcode[5:2] == 4'h5)
            o_kind = `NPEC_OP_CFG;
         else if (i_opcode[5:2] == 4'h4)
            o_kind = `NPEC_OP_EE;
      end
      else if (i_opcode[5:2] == 4'h1)
      begin
         o_kind = `NPEC_OP_PROG;
         o_rows = 3'h1;
      end
   end
endmodule // npec_decode

// ==== hw/npec_timer.sv ====
// Self-timed operation duration counter
`timescale 1ns/10ps
`include "npec_consts.svh"
module npec_timer
#(
   parameter int unsigned OP_CYCLES = `NPEC_OP_CYCLES
)
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // Control
   input wire logic i_load,
   input wire logic i_abort,
   output logic o_done
);
   logic [31:0] count_r;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset || i_abort)
         count_r <= 32'h0;
      else if (i_load)
         count_r <= OP_CYCLES;
      else if (count_r != 32'h0)
         count_r <= count_r - 32'h1;
   end

   assign o_done = (count_r == 32'h1) && !i_load;
endmodule // npec_timer

// ==== tb/npec_chk.sv ====
// Assertion checker for the program and erase control block
`timescale 1ns/10ps
`include "npec_consts.svh"
module npec_chk
#(
   parameter int unsigned OP_CYCLES = 2000
)
(
   // Clock, reset and pins
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_serial_prog,
   input wire logic i_abort,
   // Array command
   input wire npec_pkg::npec_cmd_t o_cmd,
   input wire logic o_cmd_valid,
   input wire logic o_eeprom_program_only,
   input wire logic o_busy
);
   logic [31:0] cnt_r;
   logic ab_r;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   // Busy length and abort seen
   always_ff @(posedge i_clk_sys)
   begin
      cnt_r <= o_busy ? cnt_r + 32'h1 : 32'h0;
      ab_r <= o_busy && (ab_r || i_abort);
   end
   AST_VALID: assert property (o_cmd_valid == o_busy)
      else $error("command valid differs from busy");
   AST_LEN: assert property ($fell(o_busy) |-> ab_r || cnt_r == OP_CYCLES)
      else $error("busy length wrong");
   AST_HOLD: assert property (o_busy && $past(o_busy) |-> $stable(o_cmd))
      else $error("command changed while busy");
   AST_EE: assert property (o_eeprom_program_only |->
      o_cmd.kind == `NPEC_OP_EE)
      else $error("program only outside eeprom");
   AST_ROWS: assert property (o_busy && o_cmd.kind == `NPEC_OP_ROW |->
      o_cmd.rows inside {3'h1, 3'h2, 3'h4})
      else $error("bad row count");
   AST_SER: assert property ($rose(o_busy) && o_cmd.kind inside
      {`NPEC_OP_BOOT, `NPEC_OP_ALL} |-> i_serial_prog)
      else $error("serial only erase outside serial mode");
   AST_NOP: assert property (o_busy |-> o_cmd.kind != `NPEC_OP_NONE)
      else $error("busy without operation");
   AST_RST: assert property ($past(i_reset) |-> !o_busy)
      else $error("busy after reset");
endmodule // npec_chk
bind npec_ctrl npec_chk #(.OP_CYCLES(OP_CYCLES)) chk_u (.i_clk_sys,
   .i_reset, .i_serial_prog, .i_abort, .o_cmd, .o_cmd_valid,
   .o_eeprom_program_only, .o_busy);

// ==== tb/npec_ctrl_tb.sv ====
// Testbench for the program and erase control block
`timescale 1ns/10ps
`include "npec_consts.svh"
module npec_ctrl_tb;
   logic clk = 0, rst = 1, hsel = 0, hwrite = 0, sprog = 0, abort = 0;
   logic [1:0] htrans = 2'h0;
   logic [11:0] haddr = 12'h000;
   logic [31:0] hwdata = 32'h0, rdata, r;
   logic hready, hresp, cvalid, eepo, busy;
   npec_pkg::npec_cmd_t cmd;
   int error_cnt = 0, comparisons = 0;
   npec_ctrl #(.OP_CYCLES(8)) dut_u (.i_clk_sys(clk), .i_reset(rst),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(rdata),
      .o_hreadyout(hready), .o_hresp(hresp), .i_serial_prog(sprog),
      .i_abort(abort), .o_cmd(cmd), .o_cmd_valid(cvalid),
      .o_eeprom_program_only(eepo), .o_busy(busy));
   initial forever #5 clk = ~clk;
   task automatic results;
      if (error_cnt == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = rdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic op(input logic [15:0] f, input logic [2:0] k, n);
      bus(1, 12'h004, 32'h00abcdef);
      bus(1, 12'h000, {16'h0, f});
      bus(1, 12'h000, {16'h0, f | 16'h8000});
      @(posedge clk);
      #1;
      chk("busy", {31'h0, k != 3'h0}, {31'h0, busy});
      if (k != 3'h0)
      begin
         chk("kind", {29'h0, k}, {29'h0, cmd.kind});
         chk("addr", 32'h00abcdef, {8'h0, cmd.addr});
         chk("eeprom only", {31'h0, f[12] && k == `NPEC_OP_EE}, {31'h0, eepo});
         if (n != 3'h0)
            chk("rows", {29'h0, n}, {29'h0, cmd.rows});
         bus(1, 12'h000, {16'h0, f});
         chk("start held", 32'h1, {31'h0, busy});
         repeat (40) if (busy === 1'b1) @(posedge clk);
         bus(0, 12'h008, 32'h0);
         chk("status", {29'h0, k}, r);
      end
      bus(0, 12'h000, 32'h0);
      chk("control", {16'h0, f & 16'h507f | (k == 3'h0 ? 16'h2000 : 16'h0)}, r);
   endtask
   initial
   begin
      #50000;
      error_cnt++;
      results;
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      bus(0, 12'h000, 32'h0);
      chk("reset control", 32'h0, r);
      op(16'h4fd8, `NPEC_OP_ROW, 3'h1);
      op(16'h4059, `NPEC_OP_ROW, 3'h2);
      op(16'h405a, `NPEC_OP_ROW, 3'h4);
      op(16'h4054, `NPEC_OP_CFG, 3'h0);
      op(16'h5050, `NPEC_OP_EE, 3'h0);
      op(16'h5004, `NPEC_OP_PROG, 3'h0);
      op(16'h4044, `NPEC_OP_NONE, 3'h0);
      op(16'h0058, `NPEC_OP_NONE, 3'h0);
      op(16'h407f, `NPEC_OP_NONE, 3'h0);
      op(16'h4068, `NPEC_OP_NONE, 3'h0);
      sprog <= 1'b1;
      op(16'h4068, `NPEC_OP_BOOT, 3'h0);
      op(16'h4064, `NPEC_OP_ALL, 3'h0);
      bus(1, 12'h000, 32'h0000c058);
      @(posedge clk);
      abort <= 1'b1;
      repeat (40) if (busy !== 1'b0) @(posedge clk);
      abort <= 1'b0;
      bus(0, 12'h000, 32'h0);
      chk("abort control", 32'h00006058, r);
      results;
   end
endmodule // npec_ctrl_tb
